// >>> umh_params.svh
// umh_params.svh: constants of the modem handshake block
// Assumes: included by the package and by every design file of the block
//
// What this block does
// - Each port's send-request pin is the inverse of control bit 1.
// - Each port's terminal-ready pin is the inverse of control bit 0.
// - Reset drives port 1 send-request pin inactive high; port 2's is left undriven to the board pull.
// - Reset drives every terminal-ready pin to its inactive high level.
// - Loopback holds both handshake pins of that port inactive.
// - Port 2 send-request pin is latched at reset release to pick base.
// - Status bit 4 reads the inverse of the clear-to-send pin.
// - Status bit 0 sets when clear-to-send rises since the last read.
// - Status bit 5 reads the inverse of the set-ready pin.
// - Status bit 1 sets when set-ready rises since the last read.
// - Status bit 7 reads the inverse of the carrier-detect pin.
// - Status bit 3 sets when carrier-detect rises since the last read.
// - Status bit 6 reads the inverse of the ring-indicator pin.
// - Status bit 2 sets when ring-indicator rises since the last read.
// - With enable bit 3 set, any status input change raises the interrupt.
// - Clear-to-send only feeds status and interrupt, never transmit logic.
`ifndef UMH_PARAMS_SVH
`define UMH_PARAMS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define UMH_PORTS          2
`define UMH_LINES          4
`define UMH_BASE_W         16

// ****************************************************************
// Field positions
// ****************************************************************
`define UMH_CTL_TERM_READY 0
`define UMH_CTL_REQ_SEND   1
`define UMH_LINE_CTS       0
`define UMH_LINE_DSR       1
`define UMH_LINE_RI        2
`define UMH_LINE_DCD       3

// ****************************************************************
// Reset and strap values
// ****************************************************************
`define UMH_PIN_INACTIVE   1'b1
`define UMH_INDEX_BASE_LOW  16'h03f0
`define UMH_INDEX_BASE_HIGH 16'h0370

`endif

// >>> umh_pkg.sv
// umh_pkg.sv: types of the modem handshake block
// Assumes: umh_params.svh is reachable by bare name
`include "umh_params.svh"

package umh_pkg;

  typedef logic [`UMH_LINES-1:0] umh_lines_t;

  typedef struct packed {
    umh_lines_t first;
    umh_lines_t second;
  } umh_sync_t;

  typedef struct packed {
    logic first;
    logic second;
    logic armed;
    logic strap;
  } umh_strap_t;

  typedef struct packed {
    logic [`UMH_PORTS-1:0]                req_send_n;
    logic [`UMH_PORTS-1:0]                term_ready_n;
    logic [`UMH_PORTS-1:0][`UMH_LINES-1:0] line_state;
    logic [`UMH_PORTS-1:0][`UMH_LINES-1:0] delta;
    logic [`UMH_PORTS-1:0]                pending;
    logic [`UMH_BASE_W-1:0]               config_base;
  } umh_state_t;

endpackage

// >>> umh_sync.sv
// umh_sync.sv: two-stage synchroniser for one port's modem inputs
// Assumes: inputs are asynchronous pins; no reset needed on data stages
`timescale 1ns/10ps
`include "umh_params.svh"

module umh_sync (
  input  wire logic                i_clock,
  input  wire logic                i_clock_enable,
  input  wire umh_pkg::umh_lines_t i_lines,
  output umh_pkg::umh_lines_t      o_lines
);
  import umh_pkg::*;

  umh_sync_t st;
  umh_sync_t next_st;

  always_comb begin
    next_st        = st;
    next_st.first  = i_lines;
    // First stage feeds only the second
    next_st.second = st.first;
  end

  always_ff @(posedge i_clock) begin
    if (i_clock_enable) begin
      st <= next_st;
    end
  end

  assign o_lines = st.second;

endmodule

// >>> umh_strap.sv
// umh_strap.sv: latches the base-select strap at reset release
// Assumes: the board holds the strap level across the release of reset
`timescale 1ns/10ps
`include "umh_params.svh"

module umh_strap (
  input  wire logic i_clock,
  input  wire logic i_clock_enable,
  input  wire logic i_reset,
  input  wire logic i_strap_pin,
  output logic      o_strap,
  output logic      o_strap_valid
);
  import umh_pkg::*;

  umh_strap_t st;
  umh_strap_t next_st;

  always_comb begin
    next_st        = st;
    // Sync stages run through reset so the level is ready at release
    next_st.first  = i_strap_pin;
    next_st.second = st.first;
    if (!st.armed) begin
      next_st.strap = st.second;
      next_st.armed = 1'b1;
    end
    if (i_reset) begin
      next_st.armed = 1'b0;
      next_st.strap = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_clock_enable) begin
      st <= next_st;
    end
  end

  assign o_strap       = st.strap;
  assign o_strap_valid = st.armed;

  // ****************************************************************
  // Checks
  // ****************************************************************
  strap_latch_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_clock_enable && !st.armed |=> o_strap == $past(st.second)
      && o_strap_valid)
    else $error("strap not latched at reset release");

  strap_hold_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    st.armed |=> $stable(o_strap))
    else $error("strap changed after latching");

endmodule

// >>> umh_modem_ctrl.sv
// umh_modem_ctrl.sv: modem handshake logic for both serial ports
// Assumes: modem pins are asynchronous; control bits and the status
// read strobe come from register logic on i_clock
`timescale 1ns/10ps
`include "umh_params.svh"

module umh_modem_ctrl (
  input  wire logic        i_clock,
  input  wire logic        i_clock_enable,
  input  wire logic        i_reset,
  // Port 1 register side
  input  wire logic [1:0]  i_modem_control_reg_port1,
  input  wire logic        i_loopback_port1,
  input  wire logic        i_msi_enable_port1,
  input  wire logic        i_status_read_port1,
  output logic [7:0]       o_modem_status_reg_port1,
  output logic             o_modem_int_port1,
  // Port 2 register side
  input  wire logic [1:0]  i_modem_control_reg_port2,
  input  wire logic        i_loopback_port2,
  input  wire logic        i_msi_enable_port2,
  input  wire logic        i_status_read_port2,
  output logic [7:0]       o_modem_status_reg_port2,
  output logic             o_modem_int_port2,
  // Port 1 modem pins
  input  wire logic        i_clear_send_in_port1_n,
  input  wire logic        i_set_ready_in_port1_n,
  input  wire logic        i_carrier_detect_in_port1_n,
  input  wire logic        i_ring_indicator_in_port1_n,
  output logic             o_req_send_out_port1_n,
  output logic             o_term_ready_out_port1_n,
  // Port 2 modem pins
  input  wire logic        i_clear_send_in_port2_n,
  input  wire logic        i_set_ready_in_port2_n,
  input  wire logic        i_carrier_detect_in_port2_n,
  input  wire logic        i_ring_indicator_in_port2_n,
  output logic             o_req_send_out_port2_n,
  output logic             o_req_send_oe_port2,
  input  wire logic        i_req_send_in_port2,
  output logic             o_term_ready_out_port2_n,
  // Strap result
  output logic             o_config_base_strap,
  output logic [15:0]      o_config_index_base
);
  import umh_pkg::*;

  // ****************************************************************
  // Gathering per-port signals
  // ****************************************************************
  logic [`UMH_PORTS-1:0][1:0] ctl_bits;
  logic [`UMH_PORTS-1:0]      loopb;
  logic [`UMH_PORTS-1:0]      msi_en;
  logic [`UMH_PORTS-1:0]      rd;
  umh_lines_t [`UMH_PORTS-1:0] raw;
  umh_lines_t [`UMH_PORTS-1:0] lines;
  logic                       strap;
  logic                       strap_valid;

  umh_state_t st;
  umh_state_t next_st;

  assign ctl_bits = {i_modem_control_reg_port2, i_modem_control_reg_port1};
  assign loopb    = {i_loopback_port2, i_loopback_port1};
  assign msi_en   = {i_msi_enable_port2, i_msi_enable_port1};
  assign rd       = {i_status_read_port2, i_status_read_port1};

  assign raw[0] = {i_carrier_detect_in_port1_n,
                   i_ring_indicator_in_port1_n,
                   i_set_ready_in_port1_n,
                   i_clear_send_in_port1_n};
  assign raw[1] = {i_carrier_detect_in_port2_n,
                   i_ring_indicator_in_port2_n,
                   i_set_ready_in_port2_n,
                   i_clear_send_in_port2_n};

  // ****************************************************************
  // Input synchronisers, one per port
  // ****************************************************************
  for (genvar g = 0; g < `UMH_PORTS; g++) begin : g_sync
    umh_sync u_sync (
      .i_clock        (i_clock),
      .i_clock_enable (i_clock_enable),
      .i_lines        (raw[g]),
      .o_lines        (lines[g])
    );
  end

  umh_strap u_strap (
    .i_clock        (i_clock),
    .i_clock_enable (i_clock_enable),
    .i_reset        (i_reset),
    .i_strap_pin    (i_req_send_in_port2),
    .o_strap        (strap),
    .o_strap_valid  (strap_valid)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    umh_lines_t rise;
    umh_lines_t change;
    rise    = '0;
    change  = '0;
    next_st = st;
    for (int p = 0; p < `UMH_PORTS; p++) begin
      // Clear-to-send never gates the send request
      next_st.req_send_n[p]   = loopb[p]
                              | ~ctl_bits[p][`UMH_CTL_REQ_SEND];
      next_st.term_ready_n[p] = loopb[p]
                              | ~ctl_bits[p][`UMH_CTL_TERM_READY];
      if (loopb[p]) begin
        next_st.req_send_n[p]   = `UMH_PIN_INACTIVE;
        next_st.term_ready_n[p] = `UMH_PIN_INACTIVE;
      end
      // Status holds inverted pin levels
      next_st.line_state[p] = ~lines[p];
      // Pin low to high means stored status 1 and pin now high
      rise   = st.line_state[p] & lines[p];
      change = st.line_state[p] ^ ~lines[p];
      // Set wins over the clear of a read in the same cycle
      next_st.delta[p] = (rd[p] ? '0 : st.delta[p]) | rise;
      next_st.pending[p] = (st.pending[p] & ~rd[p])
                         | (|change);
    end
    if (strap_valid) begin
      next_st.config_base = strap ? `UMH_INDEX_BASE_HIGH
                                  : `UMH_INDEX_BASE_LOW;
    end
    if (i_reset) begin
      next_st.req_send_n   = '1;
      next_st.term_ready_n = '1;
      next_st.delta        = '0;
      next_st.pending      = '0;
      next_st.config_base  = `UMH_INDEX_BASE_LOW;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_clock_enable) begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_req_send_out_port1_n   = st.req_send_n[0];
  assign o_req_send_out_port2_n   = st.req_send_n[1];
  assign o_term_ready_out_port1_n = st.term_ready_n[0];
  assign o_term_ready_out_port2_n = st.term_ready_n[1];
  // Released only after the strap is taken, so the board level wins
  assign o_req_send_oe_port2      = strap_valid;

  // Bits 7:4 are the inverted pins, bits 3:0 the change flags
  assign o_modem_status_reg_port1 = {st.line_state[0], st.delta[0]};
  assign o_modem_status_reg_port2 = {st.line_state[1], st.delta[1]};

  // Enable gates the output only; a change seen while off stays pending
  assign o_modem_int_port1 = st.pending[0] & msi_en[0];
  assign o_modem_int_port2 = st.pending[1] & msi_en[1];

  assign o_config_base_strap = strap;
  assign o_config_index_base = st.config_base;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  for (genvar p = 0; p < `UMH_PORTS; p++) begin : g_chk

    rts_follow_a: assert property (
      i_clock_enable && !loopb[p]
      |=> st.req_send_n[p] == !$past(ctl_bits[p][`UMH_CTL_REQ_SEND]))
      else $error("send request does not follow control bit");

    dtr_follow_a: assert property (
      i_clock_enable && !loopb[p]
      |=> st.term_ready_n[p] == !$past(ctl_bits[p][`UMH_CTL_TERM_READY]))
      else $error("terminal ready does not follow control bit");

    rts_reset_a: assert property (
      @(posedge i_clock) disable iff (1'b0)
      i_reset && i_clock_enable |=> st.req_send_n[p])
      else $error("send request active after reset");

    dtr_reset_a: assert property (
      @(posedge i_clock) disable iff (1'b0)
      i_reset && i_clock_enable |=> st.term_ready_n[p])
      else $error("terminal ready active after reset");

    loop_quiet_a: assert property (
      i_clock_enable && loopb[p] [*2]
      |=> st.req_send_n[p] && st.term_ready_n[p])
      else $error("handshake pin active in loopback");

    cts_mirror_a: assert property (
      i_clock_enable
      |=> st.line_state[p][`UMH_LINE_CTS]
          == !$past(lines[p][`UMH_LINE_CTS]))
      else $error("status bit 4 wrong");

    cts_delta_a: assert property (
      i_clock_enable && st.line_state[p][`UMH_LINE_CTS]
      && lines[p][`UMH_LINE_CTS] |=> st.delta[p][`UMH_LINE_CTS])
      else $error("status bit 0 not set on rise");

    dsr_mirror_a: assert property (
      i_clock_enable
      |=> st.line_state[p][`UMH_LINE_DSR]
          == !$past(lines[p][`UMH_LINE_DSR]))
      else $error("status bit 5 wrong");

    dsr_delta_a: assert property (
      i_clock_enable && st.line_state[p][`UMH_LINE_DSR]
      && lines[p][`UMH_LINE_DSR] |=> st.delta[p][`UMH_LINE_DSR])
      else $error("status bit 1 not set on rise");

    dcd_mirror_a: assert property (
      i_clock_enable
      |=> st.line_state[p][`UMH_LINE_DCD]
          == !$past(lines[p][`UMH_LINE_DCD]))
      else $error("status bit 7 wrong");

    dcd_delta_a: assert property (
      i_clock_enable && st.line_state[p][`UMH_LINE_DCD]
      && lines[p][`UMH_LINE_DCD] |=> st.delta[p][`UMH_LINE_DCD])
      else $error("status bit 3 not set on rise");

    ri_mirror_a: assert property (
      i_clock_enable
      |=> st.line_state[p][`UMH_LINE_RI]
          == !$past(lines[p][`UMH_LINE_RI]))
      else $error("status bit 6 wrong");

    ri_delta_a: assert property (
      i_clock_enable && st.line_state[p][`UMH_LINE_RI]
      && lines[p][`UMH_LINE_RI] |=> st.delta[p][`UMH_LINE_RI])
      else $error("status bit 2 not set on rise");

    change_int_a: assert property (
      i_clock_enable && msi_en[p]
      && (st.line_state[p] != ~lines[p]) ##1 msi_en[p]
      |-> (p == 0 ? o_modem_int_port1 : o_modem_int_port2))
      else $error("no interrupt on status change");

    cts_ignored_a: assert property (
      i_clock_enable && !loopb[p]
      && $changed(lines[p][`UMH_LINE_CTS])
      |=> st.req_send_n[p] == !$past(ctl_bits[p][`UMH_CTL_REQ_SEND]))
      else $error("clear-to-send disturbed send request");

    read_clear_a: assert property (
      i_clock_enable && rd[p]
      && (st.line_state[p] == ~lines[p])
      |=> st.delta[p] == '0 && !st.pending[p])
      else $error("status read did not clear flags");

    delta_only_a: assert property (
      i_clock_enable && !rd[p]
      |=> st.delta[p] == ($past(st.delta[p])
          | ($past(st.line_state[p]) & $past(lines[p]))))
      else $error("change flag moved without a rise or read");

    pending_hold_a: assert property (
      i_clock_enable && st.pending[p] && !rd[p] |=> st.pending[p])
      else $error("pending interrupt lost without a read");

    int_gate_a: assert property (
      !msi_en[p] |-> !(p == 0 ? o_modem_int_port1 : o_modem_int_port2))
      else $error("interrupt raised while disabled");

    delta_read_c: cover property (
      i_clock_enable && rd[p] && (|st.delta[p]));
    int_raise_c: cover property (
      i_clock_enable && !st.pending[p] ##1 st.pending[p] && msi_en[p]);
    loop_c: cover property (
      loopb[p] && ctl_bits[p] == 2'h3 ##1 loopb[p]);
  end

  strap_high_c: cover property (
    strap_valid && strap && o_config_index_base == `UMH_INDEX_BASE_HIGH);

  strap_low_c: cover property (
    strap_valid && !strap && o_config_index_base == `UMH_INDEX_BASE_LOW);

  base_select_a: assert property (
    i_clock_enable && strap_valid
    |=> o_config_index_base == ($past(strap) ? `UMH_INDEX_BASE_HIGH
                                             : `UMH_INDEX_BASE_LOW))
    else $error("index base does not match strap");

  oe_reset_a: assert property (
    @(posedge i_clock) disable iff (1'b0)
    i_reset && i_clock_enable |=> !o_req_send_oe_port2)
    else $error("send pin driven during reset");

endmodule

// >>> umh_modem_model.sv
// umh_modem_model.sv: modem and board seen from the handshake pins
// Assumes: bench commands line levels; board pull sets the strap level
`timescale 1ns/10ps

module umh_modem_model (
  input  wire logic [3:0] i_lines_port1,
  input  wire logic [3:0] i_lines_port2,
  input  wire logic       i_board_level,
  input  wire logic       i_req_send_n_port2,
  input  wire logic       i_req_send_oe_port2,
  output logic      [3:0] o_pins_port1,
  output logic      [3:0] o_pins_port2,
  output logic            o_strap_wire
);
  // ****************************************************************
  // Modem lines
  // ****************************************************************
  // Skewed against the clock, as a real modem is not synchronous
  assign #7 o_pins_port1 = i_lines_port1;
  assign #7 o_pins_port2 = i_lines_port2;

  // ****************************************************************
  // Strap
  // ****************************************************************
  // Board pull holds the level while the device leaves the pin free
  assign o_strap_wire = i_req_send_oe_port2 ? i_req_send_n_port2
                                            : i_board_level;
endmodule

// >>> testbench.sv
// testbench.sv: random self-checking bench of the modem handshake block
// Assumes: umh_pkg and umh_modem_model compiled before this file
`timescale 1ns/10ps

module testbench;
  import umh_pkg::*;
  logic            clock = 1'b0;
  logic            reset = 1'b1;
  logic            clk_en = 1'b1;
  logic [1:0][1:0] ctl = '0;
  logic [1:0]      loopb = '0;
  logic [1:0]      msi = '0;
  logic [1:0]      rd = '0;
  logic [1:0][3:0] lines = '1;
  logic            board_level = 1'b0;
  logic [1:0][7:0] st;
  logic [1:0]      intr;
  logic [1:0]      rs_n;
  logic [1:0]      tr_n;
  logic            oe2;
  logic            strap_wire;
  logic            strap;
  logic [15:0]     base;
  logic [3:0]      pins1;
  logic [3:0]      pins2;
  logic [1:0][3:0] exp_d;
  logic [1:0]      exp_pnd;
  logic [3:0]      old_l;
  logic [1:0]      held_rs;
  logic [7:0]      exp_s;
  int              n_fail = 0;
  int              check_count = 0;
  int              cycles = 0;
  int              p;
  int unsigned     seed_ret;

  always #25 clock = ~clock;

  umh_modem_model model_u (
    .i_lines_port1       (lines[0]),
    .i_lines_port2       (lines[1]),
    .i_board_level       (board_level),
    .i_req_send_n_port2  (rs_n[1]),
    .i_req_send_oe_port2 (oe2),
    .o_pins_port1        (pins1),
    .o_pins_port2        (pins2),
    .o_strap_wire        (strap_wire)
  );

  umh_modem_ctrl dut_u (
    .i_clock                     (clock),
    .i_clock_enable              (clk_en),
    .i_reset                     (reset),
    .i_modem_control_reg_port1   (ctl[0]),
    .i_loopback_port1            (loopb[0]),
    .i_msi_enable_port1          (msi[0]),
    .i_status_read_port1         (rd[0]),
    .o_modem_status_reg_port1    (st[0]),
    .o_modem_int_port1           (intr[0]),
    .i_modem_control_reg_port2   (ctl[1]),
    .i_loopback_port2            (loopb[1]),
    .i_msi_enable_port2          (msi[1]),
    .i_status_read_port2         (rd[1]),
    .o_modem_status_reg_port2    (st[1]),
    .o_modem_int_port2           (intr[1]),
    .i_clear_send_in_port1_n     (pins1[0]),
    .i_set_ready_in_port1_n      (pins1[1]),
    .i_ring_indicator_in_port1_n (pins1[2]),
    .i_carrier_detect_in_port1_n (pins1[3]),
    .o_req_send_out_port1_n      (rs_n[0]),
    .o_term_ready_out_port1_n    (tr_n[0]),
    .i_clear_send_in_port2_n     (pins2[0]),
    .i_set_ready_in_port2_n      (pins2[1]),
    .i_ring_indicator_in_port2_n (pins2[2]),
    .i_carrier_detect_in_port2_n (pins2[3]),
    .o_req_send_out_port2_n      (rs_n[1]),
    .o_req_send_oe_port2         (oe2),
    .i_req_send_in_port2         (strap_wire),
    .o_term_ready_out_port2_n    (tr_n[1]),
    .o_config_base_strap         (strap),
    .o_config_index_base         (base)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] expv);
    check_count++;
    if (seen !== expv) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // Pin level from a control bit; loopback wins
  function automatic logic exp_pin(input logic ctl_bit, input logic lp);
    return lp | ~ctl_bit;
  endfunction

  function automatic logic [7:0] exp_status(input logic [3:0] l,
                                            input logic [3:0] d);
    return {~l, d};
  endfunction

  task automatic do_reset(input logic lvl);
    board_level = lvl;
    ctl = '1;
    reset = 1'b1;
    tick(3);
    check("req_send_n", rs_n, 2'h3);
    check("term_ready_n", tr_n, 2'h3);
    check("oe_port2", oe2, 1'b0);
    reset = 1'b0;
    tick(2);
    check("strap", strap, lvl);
    check("index_base", base, lvl ? 16'h0370 : 16'h03f0);
    check("oe_port2", oe2, 1'b1);
    $display("test reset strap %0d done", lvl);
  endtask

  task automatic read_port(input int q);
    rd[q] = 1'b1;
    tick(1);
    rd[q] = 1'b0;
    exp_d[q] = '0;
    exp_pnd[q] = 1'b0;
    check("delta_after_read", st[q][3:0], 4'h0);
    check("int_after_read", intr[q], 1'b0);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run needs under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles >= 5000) begin
      n_fail++;
      give_verdict;
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    seed_ret = $urandom(32'h38974cdd);
    do_reset(1'b0);
    // Control bits, loopback, clear-send noise, clock freeze
    for (int i = 0; i < 32; i++) begin
      ctl[0] = i[1:0];
      loopb[0] = i[2];
      ctl[1] = 2'($urandom);
      loopb[1] = 1'($urandom);
      lines[0][0] = 1'($urandom);
      lines[1][0] = 1'($urandom);
      tick(2);
      for (int q = 0; q < 2; q++) begin
        check("send_n", rs_n[q], exp_pin(ctl[q][1], loopb[q]));
        check("ready_n", tr_n[q], exp_pin(ctl[q][0], loopb[q]));
      end
    end
    held_rs = rs_n;
    clk_en = 1'b0;
    loopb = '0;
    ctl = ~ctl;
    tick(3);
    check("frozen_req_send_n", rs_n, held_rs);
    clk_en = 1'b1;
    tick(2);
    check("req_send_n", rs_n, {~ctl[1][1], ~ctl[0][1]});
    $display("test control pins done");
    // Status lines, change flags, interrupt
    tick(4);
    read_port(0);
    read_port(1);
    for (int i = 0; i < 48; i++) begin
      p = (i < 8) ? i / 4 : int'($urandom % 2);
      old_l = lines[p];
      lines[p] = (i < 16) ? old_l ^ (4'h1 << (i % 4)) : 4'($urandom);
      msi = 2'($urandom);
      exp_d[p] = exp_d[p] | (lines[p] & ~old_l);
      if (lines[p] != old_l)
        exp_pnd[p] = 1'b1;
      tick(4);
      for (int q = 0; q < 2; q++) begin
        exp_s = exp_status(lines[q], exp_d[q]);
        check("status", st[q], exp_s);
        check("status_delta", st[q][3:0], exp_d[q]);
        check("modem_int", intr[q], exp_pnd[q] & msi[q]);
      end
      if ($urandom % 3 == 0)
        read_port(p);
    end
    $display("test status lines done");
    do_reset(1'b1);
    give_verdict;
  end
endmodule
